// File: dbl_map.svh
// Purpose: Offsets, field positions, message codes and times of the boot host.
// Assumes: 10 MHz system clock.
// Notes:   Definitions only.
`ifndef DBL_MAP_SVH
`define DBL_MAP_SVH

// ---------------------------------------------------------------
// Clock and times
// ---------------------------------------------------------------
`define DBL_CLK_KHZ 10000
`define DBL_T_RST_LOW_US 100
`define DBL_T_PIN_HOLD_US 10
`define DBL_T_APP_INIT_US 5000
`define DBL_T_SELF_LOAD_US 175000

// ---------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------
`define DBL_OFS_CTRL 8'h00
`define DBL_OFS_IMAGE 8'h04
`define DBL_OFS_STATUS 8'h08
`define DBL_OFS_RESP 8'h0c
`define DBL_CTRL_HOST_BIT 0
`define DBL_CTRL_AUTO_BIT 1
`define DBL_CTRL_PAR_BIT 2
`define DBL_CTRL_KICK_BIT 3
`define DBL_CTRL_WR_BIT 4
`define DBL_CTRL_RD_BIT 5
`define DBL_CTRL_PSEL_BIT 6
`define DBL_IMG_LAST_BIT 8

// ---------------------------------------------------------------
// Messages
// ---------------------------------------------------------------
`define DBL_CMD_DOWNLOAD 24'h000004
`define DBL_CMD_IMG_ACK 24'h000005
`define DBL_CMD_AB_QUERY 24'h090003
`define DBL_RSP_AB_HEAD 24'h890003
`define DBL_RSP_AB_VALUE 24'h000000
`define DBL_CMD_START_DECODE 24'h000000
`define DBL_ST_BOOT_START 8'h01
`define DBL_ST_IMAGE_OK 8'h02

`endif

// File: dbl_pkg.sv
// Purpose: Types of the boot host.
// Assumes: Nothing.
// Notes:   State codes are left to the tool.
package dbl_pkg;
   typedef enum logic [4:0] {
      ST_IDLE, ST_RST_LOW, ST_PIN_HOLD, ST_AB_WAIT, ST_AB_SEND, ST_AB_READ, ST_AB_CHECK, ST_AB_GAP,
      ST_SEND_DL, ST_READ_START, ST_LOAD, ST_READ_END, ST_SEND_ACK, ST_POST_WAIT, ST_READY,
      ST_SEND_KICK, ST_FAILED
   } dbl_state_t;
endpackage

// File: dbl_wait_timer.sv
// Purpose: Down counter that pulses when a loaded wait has run out.
// Assumes: One clock, clock enable freezes it.
// Notes:   Done pulses count cycles after the start pulse.
`timescale 1ns/1ps
`default_nettype none
module dbl_wait_timer (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic [23:0] count_in,
   output logic done_out
);
   logic [23:0] cnt_q;

   assign done_out = ce_in && (cnt_q == 24'h000001);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cnt_q <= 24'h000000;
      end else if (ce_in) begin
         if (start_in) begin
            cnt_q <= count_in;
         end else if (cnt_q != 24'h000000) begin
            cnt_q <= cnt_q - 24'h000001;
         end
      end
   end
endmodule // dbl_wait_timer
`default_nettype wire

// File: dbl_boot_host.sv
// Purpose: Host controller that boots the audio decoder by download or self-load.
// Assumes: A host-port engine outside carries words and bytes; it shares CLK_SYS_IN.
// Notes:   Software orders boots through CTRL and streams the image through IMAGE.
// Notes on behaviour
// R1 - Hold reset low with chosen mode pins
// R2 - Send download command after reset release
// R3 - Image bytes only after boot-start byte
// R4 - Device reports failure byte then halts
// R5 - Retry reset and command once on failure
// R6 - Checksum good gives success, bad halts
// R7 - Acknowledge success with application-reset command
// R8 - Wait 5 ms before any configuration
// R9 - Parallel reads wait for output-ready flag
// R10 - Device samples mode pins at reset rise
// R11 - Self-load only with serial host mode
// R12 - Shared pin driven only open-drain low
// R13 - Stop driving shared pin after boot
// R14 - Device emits three address bytes per fetch
// R15 - Fourth strobe reads the ROM byte
// R16 - Three bytes form 24-bit address, top zero
// R17 - Self-load image fits 32 kilobytes
// R18 - Wait 175 ms, attention line masked
// R19 - Query word and expected two-word answer
// R20 - Wrong answer: wait, reread, then reboot
// R21 - Device idles until start-decode message
// R22 - Serial reads wait for attention line low
// R23 - Device outputs address most significant first
// R24 - Pin low around reset rise, then released
// R25 - Device ignores early or post-failure commands
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dbl_map.svh"
module dbl_boot_host #(
   parameter logic [23:0] APP_INIT_CYC = 24'(`DBL_T_APP_INIT_US * (`DBL_CLK_KHZ / 1000)),
   parameter logic [23:0] SELF_LOAD_CYC = 24'(`DBL_T_SELF_LOAD_US * (`DBL_CLK_KHZ / 1000))
) (
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   input wire logic CE_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT,
   output logic DEV_RESET_N_OUT,
   output logic DEV_WR_MODE_OUT,
   output logic DEV_RD_MODE_OUT,
   output logic DEV_PSEL_MODE_OUT,
   input wire logic SELF_LOAD_REQUEST_PIN_IN,
   output logic SELF_LOAD_REQUEST_PIN_OUT,
   output logic SELF_LOAD_REQUEST_PIN_OE_OUT,
   input wire logic HOST_OUTPUT_READY_FLAG_IN,
   output logic [23:0] TX_WORD_OUT,
   output logic TX_IS_WORD_OUT,
   output logic TX_VALID_OUT,
   input wire logic TX_READY_IN,
   output logic RX_REQ_OUT,
   input wire logic [7:0] RX_BYTE_IN,
   input wire logic RX_VALID_IN,
   output logic BOOT_DONE_OUT,
   output logic BOOT_FAIL_OUT
);
   localparam logic [23:0] RST_LOW_CYC = 24'(`DBL_T_RST_LOW_US * (`DBL_CLK_KHZ / 1000));
   localparam logic [23:0] PIN_HOLD_CYC = 24'(`DBL_T_PIN_HOLD_US * (`DBL_CLK_KHZ / 1000));

   function automatic logic dbl_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   dbl_pkg::dbl_state_t state_q;
   logic [1:0] attn_sync_q;
   logic par_q, wr_lvl_q, rd_lvl_q, psel_lvl_q, ab_mode_q;
   logic tries_q, ab_second_q, img_last_q, rd_pend_q, rx_req_q;
   logic tx_valid_q, tx_is_word_q;
   logic [23:0] tx_word_q;
   logic [7:0] last_stat_q;
   logic [47:0] resp_q;
   logic [2:0] rd_cnt_q;
   logic tmr_go_q;
   logic [23:0] tmr_load_q;
   logic dev_rst_n_q, pin_oe_q, done_q, fail_q;
   logic [31:0] rdata_q;
   logic tmr_done;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire attn_low = !attn_sync_q[1];
   wire wr_ctrl = REG_WR_IN && dbl_hit(REG_ADDR_IN, `DBL_OFS_CTRL);
   wire wr_img = REG_WR_IN && dbl_hit(REG_ADDR_IN, `DBL_OFS_IMAGE);
   wire at_rest = (state_q == dbl_pkg::ST_IDLE) || (state_q == dbl_pkg::ST_READY)
                  || (state_q == dbl_pkg::ST_FAILED);
   wire start_host = wr_ctrl && REG_WDATA_IN[`DBL_CTRL_HOST_BIT] && at_rest;
   // Self-load refused when parallel mode is asked for: the memory bus is busy then
   // R11 serial only
   wire start_auto = wr_ctrl && REG_WDATA_IN[`DBL_CTRL_AUTO_BIT] && !REG_WDATA_IN[`DBL_CTRL_PAR_BIT]
                     && at_rest && !start_host;
   wire start_kick = wr_ctrl && REG_WDATA_IN[`DBL_CTRL_KICK_BIT] && (state_q == dbl_pkg::ST_READY);
   // R9 output-ready gate
   // R22 attention gate
   wire read_ok = par_q ? HOST_OUTPUT_READY_FLAG_IN : attn_low;
   wire tx_taken = tx_valid_q && TX_READY_IN;
   wire rx_take = rd_pend_q && RX_VALID_IN;
   // R3 image after start
   wire img_wr = wr_img && (state_q == dbl_pkg::ST_LOAD) && !tx_valid_q && !img_last_q;
   wire reading = (state_q == dbl_pkg::ST_AB_READ) || (state_q == dbl_pkg::ST_READ_START)
                  || (state_q == dbl_pkg::ST_READ_END);
   // R19 expected answer
   wire resp_ok = resp_q == {`DBL_RSP_AB_HEAD, `DBL_RSP_AB_VALUE};
   wire [31:0] status_word = {12'h000, tries_q, fail_q, done_q, !tx_valid_q, 3'h0, state_q, last_stat_q};

   assign REG_RDATA_OUT = rdata_q;
   assign DEV_RESET_N_OUT = dev_rst_n_q;
   assign DEV_WR_MODE_OUT = wr_lvl_q;
   assign DEV_RD_MODE_OUT = rd_lvl_q;
   assign DEV_PSEL_MODE_OUT = psel_lvl_q;
   // R12 open-drain low only
   assign SELF_LOAD_REQUEST_PIN_OUT = 1'b0;
   assign SELF_LOAD_REQUEST_PIN_OE_OUT = pin_oe_q;
   assign TX_WORD_OUT = tx_word_q;
   assign TX_IS_WORD_OUT = tx_is_word_q;
   assign TX_VALID_OUT = tx_valid_q;
   assign RX_REQ_OUT = rx_req_q;
   assign BOOT_DONE_OUT = done_q;
   assign BOOT_FAIL_OUT = fail_q;

   dbl_wait_timer u_timer (
      .clk_in(CLK_SYS_IN),
      .rstn_in(RSTN_IN),
      .ce_in(CE_IN),
      .start_in(tmr_go_q),
      .count_in(tmr_load_q),
      .done_out(tmr_done)
   );

   // ---------------------------------------------------------------
   // Register port and pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         attn_sync_q <= 2'h3;
         rdata_q <= 32'h00000000;
         par_q <= 1'b0;
         wr_lvl_q <= 1'b0;
         rd_lvl_q <= 1'b0;
         psel_lvl_q <= 1'b0;
      end else if (CE_IN) begin
         attn_sync_q <= {attn_sync_q[0], SELF_LOAD_REQUEST_PIN_IN};
         if (REG_RD_IN && dbl_hit(REG_ADDR_IN, `DBL_OFS_CTRL)) begin
            rdata_q <= {25'h0000000, psel_lvl_q, rd_lvl_q, wr_lvl_q, 1'b0, par_q, 2'h0};
         end else if (REG_RD_IN && dbl_hit(REG_ADDR_IN, `DBL_OFS_STATUS)) begin
            rdata_q <= status_word;
         end else if (REG_RD_IN && dbl_hit(REG_ADDR_IN, `DBL_OFS_RESP)) begin
            rdata_q <= {8'h00, resp_q[23:0]};
         end else begin
            rdata_q <= 32'h00000000;
         end
         // R1 mode levels chosen
         if (wr_ctrl && at_rest) begin
            par_q <= REG_WDATA_IN[`DBL_CTRL_PAR_BIT];
            wr_lvl_q <= REG_WDATA_IN[`DBL_CTRL_WR_BIT];
            rd_lvl_q <= REG_WDATA_IN[`DBL_CTRL_RD_BIT];
            psel_lvl_q <= REG_WDATA_IN[`DBL_CTRL_PSEL_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read handshake toward the host-port engine
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         rd_pend_q <= 1'b0;
         rx_req_q <= 1'b0;
      end else if (CE_IN) begin
         rx_req_q <= 1'b0;
         if (rx_take) begin
            rd_pend_q <= 1'b0;
         end else if (reading && !rd_pend_q && read_ok) begin
            rx_req_q <= 1'b1;
            rd_pend_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Boot sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         state_q <= dbl_pkg::ST_IDLE;
         ab_mode_q <= 1'b0;
         tries_q <= 1'b0;
         ab_second_q <= 1'b0;
         img_last_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_is_word_q <= 1'b1;
         tx_word_q <= 24'h000000;
         last_stat_q <= 8'h00;
         resp_q <= 48'h000000000000;
         rd_cnt_q <= 3'h0;
         tmr_go_q <= 1'b0;
         tmr_load_q <= 24'h000000;
         dev_rst_n_q <= 1'b0;
         pin_oe_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
      end else if (CE_IN) begin
         tmr_go_q <= 1'b0;
         case (state_q)
            dbl_pkg::ST_IDLE, dbl_pkg::ST_READY, dbl_pkg::ST_FAILED: begin
               if (start_host || start_auto) begin
                  // R1 reset with mode pins
                  // R24 pin low across reset rise
                  state_q <= dbl_pkg::ST_RST_LOW;
                  ab_mode_q <= start_auto;
                  pin_oe_q <= start_auto;
                  dev_rst_n_q <= 1'b0;
                  tries_q <= 1'b0;
                  ab_second_q <= 1'b0;
                  done_q <= 1'b0;
                  fail_q <= 1'b0;
                  tmr_go_q <= 1'b1;
                  tmr_load_q <= RST_LOW_CYC;
               end else if (start_kick) begin
                  state_q <= dbl_pkg::ST_SEND_KICK;
                  tx_valid_q <= 1'b1;
                  tx_is_word_q <= 1'b1;
                  tx_word_q <= `DBL_CMD_START_DECODE;
               end
            end
            dbl_pkg::ST_RST_LOW: begin
               if (tmr_done) begin
                  dev_rst_n_q <= 1'b1;
                  if (ab_mode_q) begin
                     state_q <= dbl_pkg::ST_PIN_HOLD;
                     tmr_go_q <= 1'b1;
                     tmr_load_q <= PIN_HOLD_CYC;
                  end else begin
                     // R2 download command
                     state_q <= dbl_pkg::ST_SEND_DL;
                     tx_valid_q <= 1'b1;
                     tx_is_word_q <= 1'b1;
                     tx_word_q <= `DBL_CMD_DOWNLOAD;
                  end
               end
            end
            dbl_pkg::ST_PIN_HOLD: begin
               if (tmr_done) begin
                  // R13 line handed back to the device
                  pin_oe_q <= 1'b0;
                  state_q <= dbl_pkg::ST_AB_WAIT;
                  tmr_go_q <= 1'b1;
                  tmr_load_q <= SELF_LOAD_CYC;
               end
            end
            dbl_pkg::ST_AB_WAIT: begin
               // R18 load wait, attention ignored
               if (tmr_done) begin
                  state_q <= dbl_pkg::ST_AB_SEND;
                  tx_valid_q <= 1'b1;
                  tx_is_word_q <= 1'b1;
                  tx_word_q <= `DBL_CMD_AB_QUERY;
               end
            end
            dbl_pkg::ST_AB_SEND: begin
               if (tx_taken) begin
                  tx_valid_q <= 1'b0;
                  rd_cnt_q <= 3'h0;
                  state_q <= dbl_pkg::ST_AB_READ;
               end
            end
            dbl_pkg::ST_AB_READ: begin
               if (rx_take) begin
                  resp_q <= {resp_q[39:0], RX_BYTE_IN};
                  rd_cnt_q <= rd_cnt_q + 3'h1;
                  if (rd_cnt_q == 3'h5) begin
                     state_q <= dbl_pkg::ST_AB_CHECK;
                  end
               end
            end
            dbl_pkg::ST_AB_CHECK: begin
               // R20 reread once, then reboot once
               if (resp_ok) begin
                  state_q <= dbl_pkg::ST_READY;
                  done_q <= 1'b1;
               end else if (!ab_second_q) begin
                  ab_second_q <= 1'b1;
                  state_q <= dbl_pkg::ST_AB_GAP;
                  tmr_go_q <= 1'b1;
                  tmr_load_q <= APP_INIT_CYC;
               end else if (!tries_q) begin
                  tries_q <= 1'b1;
                  ab_second_q <= 1'b0;
                  pin_oe_q <= 1'b1;
                  dev_rst_n_q <= 1'b0;
                  state_q <= dbl_pkg::ST_RST_LOW;
                  tmr_go_q <= 1'b1;
                  tmr_load_q <= RST_LOW_CYC;
               end else begin
                  state_q <= dbl_pkg::ST_FAILED;
                  fail_q <= 1'b1;
               end
            end
            dbl_pkg::ST_AB_GAP: begin
               if (tmr_done) begin
                  state_q <= dbl_pkg::ST_AB_SEND;
                  tx_valid_q <= 1'b1;
                  tx_is_word_q <= 1'b1;
                  tx_word_q <= `DBL_CMD_AB_QUERY;
               end
            end
            dbl_pkg::ST_SEND_DL, dbl_pkg::ST_SEND_ACK, dbl_pkg::ST_SEND_KICK: begin
               if (tx_taken) begin
                  tx_valid_q <= 1'b0;
                  if (state_q == dbl_pkg::ST_SEND_DL) begin
                     state_q <= dbl_pkg::ST_READ_START;
                  end else if (state_q == dbl_pkg::ST_SEND_ACK) begin
                     // R8 application init time
                     state_q <= dbl_pkg::ST_POST_WAIT;
                     tmr_go_q <= 1'b1;
                     tmr_load_q <= APP_INIT_CYC;
                  end else begin
                     state_q <= dbl_pkg::ST_READY;
                  end
               end
            end
            dbl_pkg::ST_READ_START: begin
               if (rx_take) begin
                  last_stat_q <= RX_BYTE_IN;
                  if (RX_BYTE_IN == `DBL_ST_BOOT_START) begin
                     state_q <= dbl_pkg::ST_LOAD;
                  end else if (!tries_q) begin
                     // R5 one retry of reset and command
                     tries_q <= 1'b1;
                     dev_rst_n_q <= 1'b0;
                     state_q <= dbl_pkg::ST_RST_LOW;
                     tmr_go_q <= 1'b1;
                     tmr_load_q <= RST_LOW_CYC;
                  end else begin
                     // R4 device halted
                     state_q <= dbl_pkg::ST_FAILED;
                     fail_q <= 1'b1;
                  end
               end
            end
            dbl_pkg::ST_LOAD: begin
               if (img_wr) begin
                  tx_valid_q <= 1'b1;
                  tx_is_word_q <= 1'b0;
                  tx_word_q <= {16'h0000, REG_WDATA_IN[7:0]};
                  img_last_q <= REG_WDATA_IN[`DBL_IMG_LAST_BIT];
               end else if (tx_taken) begin
                  tx_valid_q <= 1'b0;
                  if (img_last_q) begin
                     img_last_q <= 1'b0;
                     state_q <= dbl_pkg::ST_READ_END;
                  end
               end
            end
            dbl_pkg::ST_READ_END: begin
               if (rx_take) begin
                  last_stat_q <= RX_BYTE_IN;
                  // R6 checksum verdict
                  if (RX_BYTE_IN == `DBL_ST_IMAGE_OK) begin
                     // R7 acknowledge success
                     state_q <= dbl_pkg::ST_SEND_ACK;
                     tx_valid_q <= 1'b1;
                     tx_is_word_q <= 1'b1;
                     tx_word_q <= `DBL_CMD_IMG_ACK;
                  end else begin
                     state_q <= dbl_pkg::ST_FAILED;
                     fail_q <= 1'b1;
                  end
               end
            end
            dbl_pkg::ST_POST_WAIT: begin
               if (tmr_done) begin
                  state_q <= dbl_pkg::ST_READY;
                  done_q <= 1'b1;
               end
            end
            default: begin
               state_q <= dbl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RSTN_IN);

   // Cycles spent in the two long waits, counted only while enabled
   logic [23:0] post_cnt_q, load_cnt_q;
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RSTN_IN) begin
         post_cnt_q <= 24'h000000;
         load_cnt_q <= 24'h000000;
      end else if (CE_IN) begin
         post_cnt_q <= (state_q == dbl_pkg::ST_POST_WAIT) ? post_cnt_q + 24'h000001 : 24'h000000;
         load_cnt_q <= (state_q == dbl_pkg::ST_AB_WAIT) ? load_cnt_q + 24'h000001 : 24'h000000;
      end
   end

   sequence s_ack_taken;
      TX_VALID_OUT && TX_IS_WORD_OUT && TX_READY_IN && CE_IN && (TX_WORD_OUT == `DBL_CMD_IMG_ACK);
   endsequence

   AST_DL_OUT_OF_RESET: assert property ( // R2
      (TX_VALID_OUT && (TX_WORD_OUT == `DBL_CMD_DOWNLOAD)) |-> (DEV_RESET_N_OUT && !SELF_LOAD_REQUEST_PIN_OE_OUT))
      else $error("download command sent while device held in reset");
   AST_IMAGE_AFTER_START: assert property ( // R3
      (TX_VALID_OUT && !TX_IS_WORD_OUT) |-> (last_stat_q == `DBL_ST_BOOT_START))
      else $error("image byte sent without boot-start status");
   AST_ACK_AFTER_OK: assert property ( // R7
      s_ack_taken |-> (last_stat_q == `DBL_ST_IMAGE_OK) ##1 (state_q == dbl_pkg::ST_POST_WAIT))
      else $error("acknowledge not tied to success status");
   AST_INIT_WAIT: assert property ( // R8
      ($rose(BOOT_DONE_OUT) && !ab_mode_q) |-> (post_cnt_q >= APP_INIT_CYC))
      else $error("boot reported done before application init time");
   AST_PAR_READ_GATE: assert property ( // R9
      (RX_REQ_OUT && par_q) |-> $past(HOST_OUTPUT_READY_FLAG_IN))
      else $error("parallel read issued without output-ready flag");
   AST_SER_READ_GATE: assert property ( // R22
      (RX_REQ_OUT && !par_q) |-> $past(attn_low))
      else $error("serial read issued while attention line high");
   AST_AUTO_SERIAL: assert property ( // R11
      SELF_LOAD_REQUEST_PIN_OE_OUT |-> !par_q)
      else $error("self-load driven with parallel host mode");
   AST_PIN_RELEASED: assert property ( // R13
      BOOT_DONE_OUT |-> !SELF_LOAD_REQUEST_PIN_OE_OUT)
      else $error("shared pin still driven after boot");
   AST_PIN_AT_EDGE: assert property ( // R24
      ($rose(DEV_RESET_N_OUT) && ab_mode_q) |-> SELF_LOAD_REQUEST_PIN_OE_OUT ##1 SELF_LOAD_REQUEST_PIN_OE_OUT)
      else $error("shared pin not held low across reset release");
   AST_LOAD_MASKED: assert property ( // R18
      ((state_q == dbl_pkg::ST_AB_SEND) && $changed(state_q) && !ab_second_q) |-> ($past(load_cnt_q) >= SELF_LOAD_CYC))
      else $error("query sent before self-load wait ended");
   AST_QUERY_WORD: assert property ( // R19
      ((state_q == dbl_pkg::ST_AB_SEND) && TX_VALID_OUT) |-> (TX_WORD_OUT == `DBL_CMD_AB_QUERY) && TX_IS_WORD_OUT)
      else $error("wrong verification request word");
endmodule // dbl_boot_host
`default_nettype wire

// File: dbl_dev_model.sv
// Purpose: Behavioural boot side of the decoder.
// Assumes: Host clock; the shared pin has a pull-up.
// Notes: Takes a word only every other cycle, so the sender sees a slow partner.
`timescale 1ns/1ps
`default_nettype none
module dbl_dev_model (
   input wire logic clk_in, input wire logic rstn_in, input wire logic pin_in,
   input wire logic [23:0] word_in, input wire logic is_word_in, input wire logic valid_in,
   input wire logic req_in, input wire logic [7:0] fail_in, input wire logic bad_in,
   output logic ready_out, output logic rx_valid_out, output logic [7:0] rx_byte_out, output logic pin_low_out
);
   logic [7:0] q[$];
   logic halt_q = 1'b0, end_q = 1'b0, self_q = 1'b0, up_q = 1'b0;
   initial begin
      ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_byte_out = 8'h00;
      pin_low_out = 1'b0;
   end
   always @(posedge clk_in) begin
      rx_valid_out <= 1'b0;
      rx_byte_out <= ~rx_byte_out;
      ready_out <= valid_in & ~ready_out & rstn_in;
      up_q <= rstn_in;
      if (rstn_in && !up_q) self_q <= !pin_in;
      // ROM fetch abstracted: the load counts as done
      if (!rstn_in) begin
         q.delete();
         halt_q <= 1'b0;
         end_q <= 1'b0;
      end else if (valid_in && ready_out && !halt_q) begin
         // download answer, ignored when halted or self-loaded
         if (is_word_in && word_in == 24'h000004 && !self_q) begin
            q.push_back(fail_in == 8'h00 ? 8'h01 : fail_in);
            halt_q <= fail_in != 8'h00;
         end
         // query answered; ack and start-decode need no reply
         if (is_word_in && word_in == 24'h090003) q = {q, 8'h89, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
         if (!is_word_in) end_q <= 1'b1;
      end
      if (rstn_in && req_in && (q.size() > 0 || end_q)) begin
         rx_valid_out <= 1'b1;
         if (q.size() > 0) rx_byte_out <= q.pop_front();
         else begin
            rx_byte_out <= bad_in ? 8'hff : 8'h02;
            halt_q <= bad_in;
            end_q <= 1'b0;
         end
      end
      // pin only pulled low, and only out of reset
      pin_low_out <= rstn_in && (q.size() > 0 || end_q);
   end
endmodule // dbl_dev_model
`default_nettype wire

// File: test_dbl_boot_host.sv
// Purpose: Self-checking bench of the boot host.
// Assumes: Device model on the far side; 10 MHz clock.
// Notes: Short wait counts keep the run small.
`timescale 1ns/1ps
`default_nettype none
`include "dbl_map.svh"
module test_dbl_boot_host;
   logic clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, bad = 1'b0;
   logic [7:0] adr = 8'h00, fail = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [23:0] last_w = 24'h0;
   int miscompares = 0, checked = 0, dl_n = 0, cyc = 0, ack_at = 0;
   wire logic [31:0] rd_w;
   wire logic [23:0] word;
   wire logic [7:0] rb;
   wire logic drst, wm, rm, pm, po, oe, dlow, isw, tv, tr, rq, rv, dn, fl;
   // Pull-up: low only while someone pulls
   wire logic pin = (oe | dlow) ? 1'b0 : 1'b1;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tv && tr && isw) begin
         last_w <= word;
         if (word == 24'h000004) dl_n <= dl_n + 1;
         if (word == 24'h000005) ack_at <= cyc;
      end
   end
   dbl_boot_host #(.APP_INIT_CYC(24'h14), .SELF_LOAD_CYC(24'h28)) u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
      .CE_IN(1'b1), .REG_ADDR_IN(adr), .REG_WDATA_IN(wd), .REG_WR_IN(we), .REG_RD_IN(re), .REG_RDATA_OUT(rd_w),
      .DEV_RESET_N_OUT(drst), .DEV_WR_MODE_OUT(wm), .DEV_RD_MODE_OUT(rm), .DEV_PSEL_MODE_OUT(pm),
      .SELF_LOAD_REQUEST_PIN_IN(pin), .SELF_LOAD_REQUEST_PIN_OUT(po), .SELF_LOAD_REQUEST_PIN_OE_OUT(oe),
      .HOST_OUTPUT_READY_FLAG_IN(dlow), .TX_WORD_OUT(word), .TX_IS_WORD_OUT(isw), .TX_VALID_OUT(tv),
      .TX_READY_IN(tr), .RX_REQ_OUT(rq), .RX_BYTE_IN(rb), .RX_VALID_IN(rv), .BOOT_DONE_OUT(dn), .BOOT_FAIL_OUT(fl));
   dbl_dev_model u_dev (.clk_in(clk), .rstn_in(drst), .pin_in(pin), .word_in(word), .is_word_in(isw),
      .valid_in(tv), .req_in(rq), .fail_in(fail), .bad_in(bad), .ready_out(tr), .rx_valid_out(rv),
      .rx_byte_out(rb), .pin_low_out(dlow));
   task automatic wrap_up();
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      adr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rd_w;
      @(posedge clk);
   endtask
   task automatic wait_end(input int n);
      repeat (n) begin
         @(posedge clk);
         if (dn === 1'b1 || fl === 1'b1) return;
      end
      miscompares++;
      wrap_up();
   endtask
   task automatic start(input logic [31:0] c);
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      wr(`DBL_OFS_CTRL, c);
   endtask
   task automatic stream();
      logic [31:0] s;
      s = 32'h0;
      for (int i = 0; i < 3000 && s[7:0] !== 8'h01; i++) rd(`DBL_OFS_STATUS, s);
      chk("start_byte", s[7:0], 8'h01);
      for (int b = 0; b < 4; b++) begin
         for (int i = 0; i < 50 && tv !== 1'b0; i++) @(posedge clk);
         if (tv !== 1'b0) begin miscompares++; wrap_up(); end
         wr(`DBL_OFS_IMAGE, {23'h0, b == 3, 8'ha0 + 8'(b)});
      end
   endtask
   task automatic s_par_ok();
      logic [31:0] s;
      start(32'h45);
      repeat (3) @(posedge clk);
      chk("mode_pins", {drst, wm, rm, pm}, 4'b0001);
      stream();
      wait_end(3000);
      rd(`DBL_OFS_STATUS, s);
      chk("end_byte", s[7:0], 8'h02);
      chk("ack_word", last_w, 24'h000005);
      chk("init_wait", 32'(cyc - ack_at >= 20), 1);
      chk("done", {dn, fl}, 2'b10);
   endtask
   task automatic s_bad();
      logic [31:0] s;
      start(32'h31);
      stream();
      wait_end(3000);
      rd(`DBL_OFS_STATUS, s);
      chk("bad_sum", {fl, s[7:0]}, 9'h1ff);
   endtask
   task automatic s_fail();
      int n0;
      n0 = dl_n;
      start(32'h01);
      wait_end(6000);
      chk("fail", {dn, fl}, 2'b01);
      chk("retries", 32'(dl_n - n0), 2);
   endtask
   task automatic s_self();
      logic [31:0] s;
      start(32'h06);
      repeat (3) @(posedge clk);
      chk("par_refused", oe, 1'b0);
      rd(8'hf0, s);
      chk("unmapped", s, 32'h0);
      start(32'h32);
      repeat (3) @(posedge clk);
      chk("pin_pulled", {oe, po}, 2'b10);
      wait_end(6000);
      rd(`DBL_OFS_RESP, s);
      chk("answer", {dn, last_w, s[23:0]}, {1'b1, 24'h090003, 24'h000000});
      chk("pin_free", oe, 1'b0);
   endtask
   initial begin
      s_par_ok();
      bad <= 1'b1;
      s_bad();
      bad <= 1'b0;
      fail <= 8'hfd;
      s_fail();
      fail <= 8'h00;
      s_self();
      wrap_up();
   end
endmodule // test_dbl_boot_host
`default_nettype wire
